// *** voc_pkg.sv ***
// package for the video offset and clip block: register map, field
// layouts, reset values, channel and mode encodings.
// assumes a 32-bit apb slave and a per-pixel channel tag on the stream.
package voc_pkg;

  localparam int PIX_W   = 12;
  localparam int CH_W    = 3;
  localparam int NUM_CH  = 8;
  localparam int FIFO_W  = PIX_W + CH_W;
  localparam int FIFO_D  = 16;
  localparam int ADDR_W  = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_OFS_PICK   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OFS_RAW    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OFS_PHYS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_AUTO_MODE  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MATCH_MODE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SAT_PICK   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SAT_RAW    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SAT_PHYS   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_TARGET     = 8'h24;

  // physical view: raw count scaled by 2^PHYS_SHIFT (fixed point)
  localparam int PHYS_SHIFT = 4;
  localparam int PHYS_W     = PIX_W + PHYS_SHIFT;

  // channel pick codes; tap n uses code for the channel slot it shares
  localparam logic [3:0] PICK_ALL   = 4'h0;
  localparam logic [3:0] PICK_RED   = 4'h1;
  localparam logic [3:0] PICK_GREEN = 4'h2;
  localparam logic [3:0] PICK_BLUE  = 4'h3;
  localparam logic [3:0] PICK_Y     = 4'h4;
  localparam logic [3:0] PICK_U     = 4'h5;
  localparam logic [3:0] PICK_V     = 4'h6;
  localparam logic [3:0] PICK_TAP1  = 4'h7;
  localparam logic [3:0] PICK_MAX   = 4'h7;

  // automatic mode codes; codes above CONT are device-specific
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_ONCE  = 2'h1;
  localparam logic [1:0] MODE_CONT  = 2'h2;
  localparam logic [1:0] MODE_HOLD  = 2'h3;

  localparam logic [PIX_W-1:0] OFS_RST    = 12'h000;
  localparam logic [PIX_W-1:0] SAT_RST    = 12'hFFF;
  localparam logic [PIX_W-1:0] TARGET_RST = 12'h040;

  // cycles between automatic adjustment steps
  localparam int STEP_DIV = 16;
  localparam int STEP_CNT_W = 4;

endpackage

// *** voc_fifo.sv ***
// parameterised fifo with valid/ready on both sides.
// assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
module voc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!rst_n)
    count_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// *** voc_core.sv ***
// video offset and clip block: per-channel dc offset, automatic offset
// and tap matching, per-channel saturation ceiling, apb registers.
// assumes pixels arrive tagged with a 3-bit channel code on clk.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps

// Function
// - add the pixel's tagged channel offset to video
// - raw offset write visible in physical view
// - physical offset write visible in raw view
// - offset pick selects which channel accessed
// - auto offset off, once, continuous modes
// - auto match equalises channel black levels to channel 0
// - extra device-specific auto mode codes allowed
// - saturation pick selects ceiling to address
// - video never exceeds channel ceiling; code clips on leaving the fifo, held pixOut not reclipped on ceiling write
// - ceiling settable raw and physical
// - raw ceiling write visible in physical
// - offset pick accepts all and channels 0 to 6
// - physical ceiling write visible in raw
module voc_core (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [voc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [voc_pkg::PIX_W-1:0]   pixIn,
  input  wire logic [voc_pkg::CH_W-1:0]    pixChIn,
  input  wire logic                        pixInValid,
  output logic                             pixInReady,
  output logic      [voc_pkg::PIX_W-1:0]   pixOut,
  output logic      [voc_pkg::CH_W-1:0]    pixChOut,
  output logic                             pixOutValid,
  input  wire logic                        pixOutReady
);
  import voc_pkg::*;

  logic [3:0]       ofsPick_q;
  logic [3:0]       satPick_q;
  logic [1:0]       autoMode_q;
  logic [1:0]       matchMode_q;
  logic [PIX_W-1:0] target_q;
  logic [PIX_W-1:0] ofs_q   [NUM_CH];
  logic [PIX_W-1:0] sat_q   [NUM_CH];
  logic [PIX_W-1:0] blackMin_q [NUM_CH];
  logic [STEP_CNT_W-1:0] stepCnt_q;
  logic             step;
  logic             autoBusy_q;
  logic             matchBusy_q;
  logic [NUM_CH-1:0] autoDone;
  logic [NUM_CH-1:0] matchDone;

  logic             wrEn;
  logic             rdEn;
  logic [2:0]       ofsIdx;
  logic [2:0]       satIdx;
  logic [PIX_W-1:0] wrRaw;
  logic [PIX_W-1:0] wrPhys;
  logic             autoActive;
  logic             addrOk;

  // ---------------- apb slave ----------------
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  assign ofsIdx  = (ofsPick_q == PICK_ALL) ? 3'd0 : 3'(ofsPick_q - 4'd1);
  assign satIdx  = (satPick_q == PICK_ALL) ? 3'd0 : 3'(satPick_q - 4'd1);
  assign wrRaw   = pwdata[PIX_W-1:0];
  assign wrPhys  = pwdata[PHYS_W-1:PHYS_SHIFT];
  assign autoActive = (autoMode_q != MODE_OFF) || (matchMode_q != MODE_OFF);

  always_comb begin
    unique case (paddr)
      OFF_OFS_PICK, OFF_OFS_RAW, OFF_OFS_PHYS, OFF_AUTO_MODE,
      OFF_MATCH_MODE, OFF_SAT_PICK, OFF_SAT_RAW, OFF_SAT_PHYS,
      OFF_STATUS, OFF_TARGET: addrOk = 1'b1;
      default:                addrOk = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addrOk;

  // read data registered in the setup phase, valid in the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rdEn) begin
      prdata <= '0;
      unique case (paddr)
        OFF_OFS_PICK:   prdata <= 32'(ofsPick_q);
        OFF_OFS_RAW:    prdata <= 32'(ofs_q[ofsIdx]);
        OFF_OFS_PHYS:   prdata <= 32'({ofs_q[ofsIdx],
                                       PHYS_SHIFT'(0)});
        OFF_AUTO_MODE:  prdata <= 32'(autoMode_q);
        OFF_MATCH_MODE: prdata <= 32'(matchMode_q);
        OFF_SAT_PICK:   prdata <= 32'(satPick_q);
        OFF_SAT_RAW:    prdata <= 32'(sat_q[satIdx]);
        OFF_SAT_PHYS:   prdata <= 32'({sat_q[satIdx],
                                       PHYS_SHIFT'(0)});
        OFF_STATUS:     prdata <= 32'({matchBusy_q, autoBusy_q});
        OFF_TARGET:     prdata <= 32'(target_q);
        default:        prdata <= '0;
      endcase
    end
  end

  // pick and target registers; out-of-range picks are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ofsPick_q <= PICK_ALL;
      satPick_q <= PICK_ALL;
      target_q  <= TARGET_RST;
    end else if (wrEn) begin
      if (paddr == OFF_OFS_PICK && pwdata[3:0] <= PICK_MAX) begin
        ofsPick_q <= pwdata[3:0];
      end
      if (paddr == OFF_SAT_PICK && pwdata[3:0] <= PICK_MAX) begin
        satPick_q <= pwdata[3:0];
      end
      if (paddr == OFF_TARGET) begin
        target_q <= wrRaw;
      end
    end
  end

  // once modes fall back to off when all channels converge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autoMode_q  <= MODE_OFF;
      matchMode_q <= MODE_OFF;
    end else begin
      if (wrEn && paddr == OFF_AUTO_MODE) begin
        autoMode_q <= pwdata[1:0];
      end else if (autoMode_q == MODE_ONCE && step && &autoDone) begin
        autoMode_q <= MODE_OFF;
      end
      if (wrEn && paddr == OFF_MATCH_MODE) begin
        matchMode_q <= pwdata[1:0];
      end else if (matchMode_q == MODE_ONCE && step && &matchDone) begin
        matchMode_q <= MODE_OFF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autoBusy_q  <= 1'b0;
      matchBusy_q <= 1'b0;
    end else begin
      autoBusy_q  <= (autoMode_q == MODE_ONCE) ||
                     (autoMode_q == MODE_CONT);
      matchBusy_q <= (matchMode_q == MODE_ONCE) ||
                     (matchMode_q == MODE_CONT);
    end
  end

  // adjustment step enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stepCnt_q <= '0;
    end else begin
      stepCnt_q <= stepCnt_q + 1'b1;
    end
  end
  assign step = (stepCnt_q == STEP_CNT_W'(STEP_DIV - 1));

  // ---------------- per-channel settings ----------------
  logic             inFire;
  logic [PIX_W:0]   refLevel;
  logic             seen_q [NUM_CH];
  // one bit wider so a dark sample plus offset cannot wrap
  assign refLevel = {1'b0, blackMin_q[0]} + {1'b0, ofs_q[0]};

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic ofsSel;
    logic satSel;
    logic runAuto;
    logic runMatch;
    logic [PIX_W:0] level;
    assign ofsSel = (ofsPick_q == PICK_ALL) || (ofsIdx == 3'(c));
    assign satSel = (satPick_q == PICK_ALL) || (satIdx == 3'(c));
    assign runAuto  = (autoMode_q == MODE_ONCE) ||
                      (autoMode_q == MODE_CONT);
    assign runMatch = (matchMode_q == MODE_ONCE) ||
                      (matchMode_q == MODE_CONT);
    assign level = {1'b0, blackMin_q[c]} + {1'b0, ofs_q[c]};
    // a channel with no sample in this step has nothing to judge
    assign autoDone[c]  = !seen_q[c] || (level == {1'b0, target_q});
    assign matchDone[c] = !seen_q[c] || !seen_q[0] || (level == refLevel);

    // darkest sample seen per channel, restarted each step
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        blackMin_q[c] <= SAT_RST;
      end else if (step) begin
        blackMin_q[c] <= SAT_RST;
      end else if (inFire && pixChIn == 3'(c) && pixIn < blackMin_q[c]) begin
        blackMin_q[c] <= pixIn;
      end
    end

    // channel had at least one sample since the last step
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        seen_q[c] <= 1'b0;
      end else if (step) begin
        seen_q[c] <= 1'b0;
      end else if (inFire && pixChIn == 3'(c)) begin
        seen_q[c] <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ofs_q[c] <= OFS_RST;
      end else if (wrEn && !autoActive && ofsSel &&
                   paddr == OFF_OFS_RAW) begin
        ofs_q[c] <= wrRaw;
      end else if (wrEn && !autoActive && ofsSel &&
                   paddr == OFF_OFS_PHYS) begin
        ofs_q[c] <= wrPhys;
      end else if (step && runAuto && !autoDone[c]) begin
        if (level < {1'b0, target_q}) begin
          ofs_q[c] <= ofs_q[c] + 1'b1;
        end else if (ofs_q[c] != '0) begin
          ofs_q[c] <= ofs_q[c] - 1'b1;
        end
      end else if (step && runMatch && !matchDone[c]) begin
        if (level < refLevel) begin
          ofs_q[c] <= ofs_q[c] + 1'b1;
        end else if (ofs_q[c] != '0) begin
          ofs_q[c] <= ofs_q[c] - 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        sat_q[c] <= SAT_RST;
      end else if (wrEn && satSel && paddr == OFF_SAT_RAW) begin
        sat_q[c] <= wrRaw;
      end else if (wrEn && satSel && paddr == OFF_SAT_PHYS) begin
        sat_q[c] <= wrPhys;
      end
    end
  end

  // ---------------- video path ----------------
  logic [FIFO_W-1:0] fOut;
  logic              fValid;
  logic              fReady;
  logic [PIX_W:0]    sum;
  logic [PIX_W-1:0]  clipped;
  logic [CH_W-1:0]   fCh;
  logic              outBusy_q;

  assign inFire = pixInValid && pixInReady;

  voc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   ({pixChIn, pixIn}),
    .inValid  (pixInValid),
    .inReady  (pixInReady),
    .outData  (fOut),
    .outValid (fValid),
    .outReady (fReady)
  );

  assign fCh = fOut[FIFO_W-1:PIX_W];
  assign sum = {1'b0, fOut[PIX_W-1:0]} + {1'b0, ofs_q[fCh]};
  always_comb begin
    if (sum > {1'b0, sat_q[fCh]}) begin
      clipped = sat_q[fCh];
    end else begin
      clipped = sum[PIX_W-1:0];
    end
  end

  assign fReady      = !outBusy_q || pixOutReady;
  assign pixOutValid = outBusy_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outBusy_q <= 1'b0;
      pixOut    <= '0;
      pixChOut  <= '0;
    end else if (fReady) begin
      outBusy_q <= fValid;
      if (fValid) begin
        pixOut   <= clipped;
        pixChOut <= fCh;
      end
    end
  end

  // ---------------- checks ----------------
  sequence s_write_once;
    wrEn && paddr == OFF_AUTO_MODE && pwdata[1:0] == MODE_ONCE;
  endsequence

  a_clip_ceiling: assert property (@(posedge clk) disable iff (!rst_n)
    pixOutValid && $stable(sat_q[pixChOut]) && !$past(wrEn)
      |-> pixOut <= sat_q[pixChOut])
    else $error("output above ceiling");

  a_manual_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && autoActive && paddr == OFF_OFS_RAW && !step
      |=> $stable(ofs_q[ofsIdx]))
    else $error("manual offset taken during auto");

  a_raw_to_phys: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && !autoActive && paddr == OFF_OFS_RAW
      |=> ofs_q[$past(ofsIdx)] == $past(wrRaw))
    else $error("raw offset not stored");

  a_phys_to_raw: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && !autoActive && paddr == OFF_OFS_PHYS
      |=> ofs_q[$past(ofsIdx)] == $past(wrPhys))
    else $error("physical offset not stored");

  a_sat_raw: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && paddr == OFF_SAT_RAW
      |=> sat_q[$past(satIdx)] == $past(wrRaw))
    else $error("raw ceiling not stored");

  a_sat_phys: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && paddr == OFF_SAT_PHYS
      |=> sat_q[$past(satIdx)] == $past(wrPhys))
    else $error("physical ceiling not stored");

  a_all_write: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && satPick_q == PICK_ALL && paddr == OFF_SAT_RAW
      |=> sat_q[0] == $past(wrRaw) &&
          sat_q[NUM_CH-1] == $past(wrRaw))
    else $error("all pick missed a channel");

  a_once_return: assert property (@(posedge clk) disable iff (!rst_n)
    autoMode_q == MODE_ONCE && step && &autoDone &&
      !(wrEn && paddr == OFF_AUTO_MODE)
      |=> autoMode_q == MODE_OFF)
    else $error("once mode did not return to off");

  a_once_starts: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_once |=> autoMode_q == MODE_ONCE ##1 autoBusy_q)
    else $error("once mode not started");
endmodule

// *** voc_core_tb_top.sv ***
// testbench for voc_core: apb register views, channel picks, pixel
// offset and clipping, fifo back-pressure, automatic offset modes.
// assumes pready answers by itself and channel index is pick minus one.
`timescale 1ns/1ps
module voc_core_tb_top;
  import voc_pkg::*;
  typedef struct {
    logic [ADDR_W-1:0] wa;
    logic [31:0]       wd;
    logic [ADDR_W-1:0] ra;
    logic [31:0]       re;
  } voc_row_s;
  logic              clk         = 1'b0;
  logic              rst_n       = 1'b0;
  logic              psel        = 1'b0;
  logic              penable     = 1'b0;
  logic              pwrite      = 1'b0;
  logic [ADDR_W-1:0] paddr       = '0;
  logic [31:0]       pwdata      = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [PIX_W-1:0]  pixIn       = '0;
  logic [CH_W-1:0]   pixChIn     = '0;
  logic              pixInValid  = 1'b0;
  logic              pixInReady;
  logic [PIX_W-1:0]  pixOut;
  logic [CH_W-1:0]   pixChOut;
  logic              pixOutValid;
  logic              pixOutReady = 1'b1;
  int                fails       = 0;
  int                checks_done = 0;
  int                cyc         = 0;
  int                n;
  logic [PIX_W-1:0]  ofsM [NUM_CH];
  logic [PIX_W-1:0]  satM [NUM_CH];
  voc_row_s          rows [10];
  logic [31:0]       rd;
  logic              er;

  always #5 clk = ~clk;

  voc_core i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixIn(pixIn),
    .pixChIn(pixChIn), .pixInValid(pixInValid),
    .pixInReady(pixInReady), .pixOut(pixOut), .pixChOut(pixChOut),
    .pixOutValid(pixOutValid), .pixOutReady(pixOutReady)
  );

  task automatic conclude();
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkPix(input logic [PIX_W-1:0] got,
                        input logic [PIX_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t pix got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, then access held until pready at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rd, e);
  endtask

  task automatic send(input logic [CH_W-1:0] c, input logic [PIX_W-1:0] p);
    @(posedge clk);
    pixIn      <= p;
    pixChIn    <= c;
    pixInValid <= 1'b1;
    do @(posedge clk); while (pixInReady !== 1'b1);
    pixInValid <= 1'b0;
  endtask

  // expected output: offset added, then held at the channel ceiling
  function automatic logic [PIX_W-1:0] expPix(input int c,
                                              input logic [PIX_W-1:0] p);
    logic [PIX_W:0] s;
    s = {1'b0, p} + {1'b0, ofsM[c]};
    return (s > {1'b0, satM[c]}) ? satM[c] : s[PIX_W-1:0];
  endfunction

  task automatic xfer(input int c, input logic [PIX_W-1:0] p);
    send(c[CH_W-1:0], p);
    do @(posedge clk); while (pixOutValid !== 1'b1);
    chkPix(pixOut, expPix(c, p));
    chkPix({{(PIX_W-CH_W){1'b0}}, pixChOut}, c[PIX_W-1:0]);
  endtask

  task automatic feed(input logic [PIX_W-1:0] p);
    for (int c = 0; c < NUM_CH; c++)
      send(c[CH_W-1:0], p);
  endtask

  initial begin
    foreach (ofsM[i]) ofsM[i] = OFS_RST;
    foreach (satM[i]) satM[i] = SAT_RST;
    rows = '{
      '{OFF_OFS_PICK, 32'h0000_0001, OFF_OFS_PICK, 32'h0000_0001},
      '{OFF_OFS_RAW, 32'h0000_0010, OFF_OFS_PHYS, 32'h0000_0100},
      '{OFF_OFS_PHYS, 32'h0000_0200, OFF_OFS_RAW, 32'h0000_0020},
      '{OFF_OFS_PICK, 32'h0000_0002, OFF_OFS_RAW, 32'h0000_0000},
      '{OFF_OFS_RAW, 32'h0000_0007, OFF_OFS_RAW, 32'h0000_0007},
      '{OFF_SAT_PICK, 32'h0000_0002, OFF_SAT_RAW, 32'h0000_0FFF},
      '{OFF_SAT_RAW, 32'h0000_0800, OFF_SAT_PHYS, 32'h0000_8000},
      '{OFF_SAT_PHYS, 32'h0000_7000, OFF_SAT_RAW, 32'h0000_0700},
      '{OFF_SAT_PICK, 32'h0000_0009, OFF_SAT_PICK, 32'h0000_0002},
      '{OFF_OFS_PICK, 32'h0000_0001, OFF_OFS_RAW, 32'h0000_0020}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chkBit(pixOutValid, 1'b0);
    chkBit(pixInReady, 1'b1);
    rdc(OFF_SAT_RAW, 32'h0000_0FFF);
    rdc(OFF_TARGET, 32'h0000_0040);
    rdc(OFF_AUTO_MODE, 32'h0000_0000);
    rdc(OFF_STATUS, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rdc(rows[i].ra, rows[i].re);
    end
    ofsM[0] = 12'h020;
    ofsM[1] = 12'h007;
    satM[1] = 12'h700;
    xfer(0, 12'h100);
    xfer(1, 12'hFF0);
    xfer(0, 12'hFF0);
    xfer(1, 12'h6F0);
    xfer(2, 12'h123);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chkBit(er, 1'b1);
    chk32(rd, 32'h0000_0000);
    // stall the output and fill the buffer until it refuses
    pixOutReady <= 1'b0;
    pixChIn     <= 3'h2;
    pixIn       <= '0;
    pixInValid  <= 1'b1;
    n = 0;
    for (int k = 0; k < 30; k++) begin
      @(posedge clk);
      if (pixInReady === 1'b1) begin
        n++;
        pixIn <= n[PIX_W-1:0];
      end
    end
    pixInValid <= 1'b0;
    chkBit(n >= FIFO_D && n <= FIFO_D + 2, 1'b1);
    chkBit(pixInReady, 1'b0);
    pixOutReady <= 1'b1;
    for (int k = 0; k < n; k++) begin
      do @(posedge clk); while (pixOutValid !== 1'b1);
      chkPix(pixOut, k[PIX_W-1:0]);
    end
    wr(OFF_OFS_PICK, 32'h0000_0000);
    wr(OFF_OFS_RAW, 32'h0000_0005);
    wr(OFF_SAT_PICK, 32'h0000_0000);
    wr(OFF_SAT_RAW, 32'h0000_0F00);
    foreach (ofsM[i]) ofsM[i] = 12'h005;
    foreach (satM[i]) satM[i] = 12'hF00;
    wr(OFF_OFS_PICK, 32'h0000_0003);
    rdc(OFF_OFS_RAW, 32'h0000_0005);
    xfer(7, 12'h100);
    xfer(3, 12'hFFF);
    wr(OFF_AUTO_MODE, {30'h0, MODE_HOLD});
    rdc(OFF_AUTO_MODE, 32'h0000_0003);
    wr(OFF_OFS_RAW, 32'h0000_0099);
    rdc(OFF_OFS_RAW, 32'h0000_0005);
    wr(OFF_AUTO_MODE, {30'h0, MODE_ONCE});
    for (int k = 0; k < 100 && rd !== 32'h0000_0000; k++) begin
      feed(12'h03B);
      apb(1'b0, OFF_AUTO_MODE, 32'h0000_0000);
    end
    chk32(rd, 32'h0000_0000);
    wr(OFF_MATCH_MODE, {30'h0, MODE_ONCE});
    rd = 32'hFFFF_FFFF;
    for (int k = 0; k < 100 && rd !== 32'h0000_0000; k++) begin
      feed(12'h03B);
      apb(1'b0, OFF_MATCH_MODE, 32'h0000_0000);
    end
    chk32(rd, 32'h0000_0000);
    wr(OFF_AUTO_MODE, {30'h0, MODE_CONT});
    for (int k = 0; k < 200 && rd !== 32'h0000_0010; k++) begin
      feed(12'h030);
      apb(1'b0, OFF_OFS_RAW, 32'h0000_0000);
    end
    chk32(rd, 32'h0000_0010);
    rdc(OFF_AUTO_MODE, 32'h0000_0002);
    rdc(OFF_STATUS, 32'h0000_0001);
    // reset in mid-run: modes and ceilings back to their reset values
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFF_AUTO_MODE, 32'h0000_0000);
    rdc(OFF_SAT_RAW, 32'h0000_0FFF);
    conclude();
  end
endmodule
